/* rtl/periph_misc_control_regs.v */
// housekeeping register bank: scratch, write unlock, irq pulse length, line test control
// How it works
// - 16-bit scratch, cleared at power-on only
// - suspend entry blocks every register write except the unlock key
// - after resume, unlock key reopens writes
// - irq pulse lasts count times unit
// - pulse length resets to one-microsecond count
// - high-speed lock holds high-speed, no chirp
// - full-speed lock holds full-speed, no chirp
// - pattern bit toggles lines pseudo-randomly
// - k bit drives lines to K
// - j bit drives lines to J
// - quiescent bit idles lines, NAKs IN
`timescale 1ns/1ps
`include "misc_regs_map.vh"
module periph_misc_control_regs (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        bus_reset,
  input  wire        suspend_enter,
  input  wire        irq_event,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [15:0] reg_rdata,
  output reg         writes_locked,
  output reg         irq_pulse,
  output reg         lock_high_speed,
  output reg         lock_full_speed,
  output reg         chirp_detect_off,
  output reg         line_drive_en,
  output reg         line_dp,
  output reg         line_dm,
  output reg         quiescent_nak_test
);
  reg  [15:0] firmware_scratch_r;
  reg  [15:0] irq_pulse_length_r;
  reg  [7:0]  line_test_control_r;
  reg         locked_r;
  reg  [8:0]  lfsr_r;
  reg  [15:0] rdata_nxt;
  wire        stretch_out;
  wire        wr_open;
  wire        hit_scratch;
  wire        hit_unlock;
  wire        hit_pulse;
  wire        hit_test;

  // address decode and write gate
  assign hit_scratch = (reg_addr == `OFS_FIRMWARE_SCRATCH);
  assign hit_unlock  = (reg_addr == `OFS_WRITE_UNLOCK_KEY);
  assign hit_pulse   = (reg_addr == `OFS_IRQ_PULSE_LENGTH);
  assign hit_test    = (reg_addr == `OFS_LINE_TEST_CONTROL);
  assign wr_open     = reg_write && !locked_r;

  // write lock: set on suspend entry, cleared only by the key or by power-on reset
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      locked_r <= 1'b0;
    else if (suspend_enter)
      locked_r <= 1'b1;
    else if (reg_write && hit_unlock && (reg_wdata == `UNLOCK_KEY_VALUE))
      locked_r <= 1'b0;
  end

  // scratch store, untouched by bus reset
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      firmware_scratch_r <= `RST_FIRMWARE_SCRATCH;
    else if (wr_open && hit_scratch)
      firmware_scratch_r <= reg_wdata;
  end

  // pulse length; power-on only default
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      irq_pulse_length_r <= `RST_IRQ_PULSE_LENGTH;
    else if (wr_open && hit_pulse)
      irq_pulse_length_r <= reg_wdata;
  end

  // test control, cleared by both resets
  always @(posedge sys_clk)
  begin
    if (!reset_n || bus_reset)
      line_test_control_r <= `RST_LINE_TEST_CONTROL;
    else if (wr_open && hit_test)
      line_test_control_r <= reg_wdata[7:0];
  end

  // pattern generator, x^9+x^5+1
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      lfsr_r <= `LFSR_SEED;
    else if (line_test_control_r[`BIT_PSEUDO_RANDOM])
      lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
  end

  // read mux; unlock key and unmapped read zero
  always @*
  begin
    rdata_nxt = 16'h0000;
    if (hit_scratch)
      rdata_nxt = firmware_scratch_r;
    else if (hit_pulse)
      rdata_nxt = irq_pulse_length_r;
    else if (hit_test)
      rdata_nxt = {8'h00, line_test_control_r};
    else if (reg_addr == `OFS_LOCK_STATUS)
      rdata_nxt = {15'h0000, locked_r};
  end

  // registered read data, one cycle after strobe only
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_read)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 16'h0000;
  end

  irq_pulse_stretch u_stretch (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .trigger   (irq_event),
    .length    (irq_pulse_length_r),
    .pulse_out (stretch_out)
  );

  // next values of the line pair, worked out before the output flops
  // so that every pin below leaves the block straight from a register
  reg         drive_en_nxt;
  reg         dp_nxt;
  reg         dm_nxt;
  reg         chirp_off_nxt;

  // line pair decode
  // the four driving bits share one pair of pins; firmware is expected
  // to keep only one of them set, but if several are set anyway the
  // pattern wins over K and K over J, so the pins never see a mix
  // one driving bit assumed; fixed priority
  always @*
  begin
    drive_en_nxt = line_test_control_r[`BIT_PSEUDO_RANDOM] |
                   line_test_control_r[`BIT_DRIVE_K] |
                   line_test_control_r[`BIT_DRIVE_J] |
                   line_test_control_r[`BIT_QUIESCENT_NAK];
    dp_nxt       = 1'b0;
    dm_nxt       = 1'b0;
    if (line_test_control_r[`BIT_PSEUDO_RANDOM])
    begin
      dp_nxt = lfsr_r[8];
      dm_nxt = ~lfsr_r[8];
    end
    else if (line_test_control_r[`BIT_DRIVE_K])
    begin
      dp_nxt = 1'b0;
      dm_nxt = 1'b1;
    end
    else if (line_test_control_r[`BIT_DRIVE_J])
    begin
      dp_nxt = 1'b1;
      dm_nxt = 1'b0;
    end
    else
    begin
      // quiescent and idle both leave the pair low;
      // only drive_en_nxt tells them apart
      dp_nxt = 1'b0;
      dm_nxt = 1'b0;
    end
  end

  // chirp detection is off while either speed is forced
  // chirp off when forced
  always @*
  begin
    chirp_off_nxt = line_test_control_r[`BIT_LOCK_HIGH_SPEED] |
                    line_test_control_r[`BIT_LOCK_FULL_SPEED];
  end

  // lock status mirror for the outside world
  // the mirror trails the lock by one cycle; a write in the cycle
  // right after the key is already accepted, whatever the pin shows
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      writes_locked <= 1'b0;
    else
      writes_locked <= locked_r;
  end

  // interrupt pulse retimed onto an output flop
  // one extra cycle of latency, but no glitch can reach the pin
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      irq_pulse <= 1'b0;
    else
      irq_pulse <= stretch_out;
  end

  // speed forcing outputs
  // both resets clear the test register, so these fall one cycle
  // after a bus reset as well as during power-on reset
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lock_high_speed  <= 1'b0;
      lock_full_speed  <= 1'b0;
      chirp_detect_off <= 1'b0;
    end
    else
    begin
      lock_high_speed  <= line_test_control_r[`BIT_LOCK_HIGH_SPEED];
      lock_full_speed  <= line_test_control_r[`BIT_LOCK_FULL_SPEED];
      chirp_detect_off <= chirp_off_nxt;
    end
  end

  // quiescent test flag for the packet engine
  // the engine answers only valid high-speed IN tokens, with NAK,
  // while this flag is high; the pins sit low at the same time
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      quiescent_nak_test <= 1'b0;
    else
      quiescent_nak_test <= line_test_control_r[`BIT_QUIESCENT_NAK];
  end

  // line pair outputs
  // enable and levels change on the same edge, so the transceiver
  // never drives a stale level for a cycle
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      line_drive_en <= 1'b0;
      line_dp       <= 1'b0;
      line_dm       <= 1'b0;
    end
    else
    begin
      line_drive_en <= drive_en_nxt;
      line_dp       <= dp_nxt;
      line_dm       <= dm_nxt;
    end
  end

  // limitations a user must know:
  // - the lock blocks only writes; reads go on as normal
  // - a write of the wrong key is silently dropped, the lock stays
  // - suspend and key in one cycle: suspend wins, the lock stays set
  // - a pulse length of zero gives no pulse at all
  // - a new event during a pulse restarts the full length
  // - the reserved test bits are stored as written and read back,
  //   but drive nothing
  // - the status register after the test control only reports the lock
endmodule // periph_misc_control_regs

/* rtl/misc_regs_map.vh */
// offsets, field positions, reset values and timing counts of the housekeeping registers
`ifndef MISC_REGS_MAP_VH
`define MISC_REGS_MAP_VH
`define OFS_FIRMWARE_SCRATCH   8'h78
`define OFS_WRITE_UNLOCK_KEY   8'h7C
`define OFS_IRQ_PULSE_LENGTH   8'h80
`define OFS_LINE_TEST_CONTROL  8'h84
`define OFS_LOCK_STATUS        8'h88
`define UNLOCK_KEY_VALUE       16'hAA37
`define RST_FIRMWARE_SCRATCH   16'h0000
`define RST_IRQ_PULSE_LENGTH   16'h001E
`define RST_LINE_TEST_CONTROL  8'h00
`define BIT_LOCK_HIGH_SPEED    7
`define BIT_RESERVED_HI        6
`define BIT_RESERVED_LO        5
`define BIT_LOCK_FULL_SPEED    4
`define BIT_PSEUDO_RANDOM      3
`define BIT_DRIVE_K            2
`define BIT_DRIVE_J            1
`define BIT_QUIESCENT_NAK      0
`define UNIT_PERIOD_PS         33300
`define CLK_PERIOD_PS          40000
// unit ticks are one clock at 25 MHz; a unit rounds up to one whole cycle
`define UNIT_CYCLES            (((`UNIT_PERIOD_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define LFSR_SEED              9'h1FF
`endif

/* rtl/irq_pulse_stretch.v */
// interrupt pulse stretcher counting units of the programmed length
`timescale 1ns/1ps
`include "misc_regs_map.vh"
module irq_pulse_stretch (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        trigger,
  input  wire [15:0] length,
  output reg         pulse_out
);
  reg [15:0] count_r;
  // load on trigger, hold output high for length units
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      count_r   <= 16'h0000;
      pulse_out <= 1'b0;
    end
    else if (trigger && (length != 16'h0000))
    begin
      count_r   <= length - 16'h0001;
      pulse_out <= 1'b1;
    end
    else if (count_r != 16'h0000)
      count_r <= count_r - 16'h0001;
    else
      pulse_out <= 1'b0;
  end
endmodule // irq_pulse_stretch

/* sim/misc_regs_sva.sv */
// checker for the housekeeping register bank
`timescale 1ns/1ps
module misc_regs_sva (
  input wire        sys_clk, reset_n, bus_reset, suspend_enter, irq_event,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata, reg_rdata,
  input wire        reg_write, reg_read, writes_locked, irq_pulse,
  input wire        lock_high_speed, lock_full_speed, chirp_detect_off,
  input wire        line_drive_en, line_dp, line_dm, quiescent_nak_test
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // correct key written this cycle
  wire key_w = reg_write && reg_addr == 8'h7C && reg_wdata == 16'hAA37;
  a_unlock_opens: assert property (key_w && !suspend_enter |=> ##1 !writes_locked)
    else $error("key kept lock");
  a_suspend_locks: assert property (suspend_enter |=> ##1 writes_locked)
    else $error("suspend left writes open");
  a_lock_holds: assert property (writes_locked && !$past(key_w) |=> writes_locked)
    else $error("lock dropped without key");
  a_key_reads_zero: assert property (reg_read && reg_addr == 8'h7C |=> reg_rdata == 16'h0000)
    else $error("key register readable");
  a_speed_no_chirp: assert property (lock_high_speed || lock_full_speed |-> chirp_detect_off)
    else $error("chirp on under speed lock");
  a_line_pair: assert property (line_drive_en && !quiescent_nak_test |-> line_dp != line_dm)
    else $error("line pair not differential");
  a_bus_reset_test: assert property (bus_reset |=> ##1 !(lock_high_speed || quiescent_nak_test))
    else $error("test bits survive bus reset");
  a_pulse_start: assert property ($rose(irq_pulse) |-> $past(irq_event, 2))
    else $error("pulse without event");
endmodule // misc_regs_sva
bind periph_misc_control_regs misc_regs_sva u_sva (.*);

/* sim/tb_top.sv */
// self-checking bench for the housekeeping register bank
`timescale 1ns/1ps
module tb_top;
  reg         sys_clk = 1'b0, reset_n = 1'b0, bus_reset = 1'b0, suspend_enter = 1'b0;
  reg         irq_event = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, v;
  reg  [15:0] reg_wdata = 16'h0000;
  wire [15:0] reg_rdata;
  wire        writes_locked, irq_pulse, lock_high_speed, lock_full_speed, chirp_detect_off;
  wire        line_drive_en, line_dp, line_dm, quiescent_nak_test;
  integer     fails = 0, samples_checked = 0, cyc = 0, n, i;
  always #20 sys_clk = ~sys_clk;
  periph_misc_control_regs uut (.*);
  // value compare
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] exp);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  // one event, count pulse cycles
  task pulse(input [15:0] exp);
    begin
      @(posedge sys_clk);
      irq_event <= 1'b1;
      @(posedge sys_clk);
      irq_event <= 1'b0;
      n = 0;
      repeat (40) @(posedge sys_clk) #1 n = n + irq_pulse;
      chk(n, exp);
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // cut a hang short
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h78, 16'h0000);
    rd(8'h80, 16'h001E);
    rd(8'h84, 16'h0000);
    pulse(16'd30);
    wr(8'h80, 16'h0001);
    pulse(16'd1);
    wr(8'h80, 16'h0007);
    pulse(16'd7);
    $display("test irq pulse done");
    for (i = 0; i < 6; i = i + 1)
    begin
      v = (i == 5) ? 8'h80 : 8'h01 << i;
      wr(8'h84, {8'h00, v});
      rd(8'h84, {8'h00, v});
      chk({lock_high_speed, lock_full_speed, chirp_detect_off, quiescent_nak_test},
          {v[7], v[4], v[7] | v[4], v[0]});
      if (v[2] | v[1] | v[0])
        chk({line_drive_en, line_dp, line_dm}, {1'b1, v[1], v[2]});
      n = 0;
      repeat (20) @(posedge sys_clk) #1 n = n + line_dp;
      if (v[3])
        chk(n > 0 && n < 20, 1'b1);
      $display("test line mode %h done", v);
    end
    wr(8'h78, 16'hA5C3);
    wr(8'h84, 16'h0081);
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    rd(8'h78, 16'hA5C3);
    rd(8'h84, 16'h0000);
    @(posedge sys_clk);
    suspend_enter <= 1'b1;
    @(posedge sys_clk);
    suspend_enter <= 1'b0;
    wr(8'h78, 16'h1111);
    rd(8'h78, 16'hA5C3);
    chk(writes_locked, 1'b1);
    wr(8'h7C, 16'hAA36);
    wr(8'h78, 16'h2222);
    rd(8'h78, 16'hA5C3);
    rd(8'h7C, 16'h0000);
    wr(8'h7C, 16'hAA37);
    wr(8'h78, 16'h3333);
    rd(8'h78, 16'h3333);
    rd(8'h40, 16'h0000);
    $display("test lock done");
    report_and_stop;
  end
endmodule // tb_top
